// *** src/gledi_top.sv ***
// General pins with LED indicator function and AXI4-Lite registers
`timescale 1ns/1ns
module gledi_top
    import gledi_pkg::*;
#(
    parameter int BLINK_CYCLES = GLEDI_BLINK_CYCLES
) (
    input wire logic clock, // Core clock, 125 MHz
    input wire logic srst, // Synchronous reset, active high
    input wire logic [7:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write byte strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [7:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    input wire logic link_up, // Valid link present
    input wire logic speed_10, // Link running at 10 Mb/s
    input wire logic full_duplex, // Link in full duplex
    input wire logic tx_activity, // Transmit activity seen
    input wire logic rx_activity, // Receive activity seen
    input wire logic [2:0] pin_in, // Pin input levels
    output logic [2:0] pin_out, // Pin output levels
    output logic [2:0] pin_oe // Pin output enables
);
    // ****************************************
    // State
    // ****************************************
    // Counter wide enough to hold one blink phase
    localparam int CW = $clog2(BLINK_CYCLES + 1);

    typedef struct packed {
        logic [2:0] dir; // 1 = output
        logic [2:0] od; // 1 = open-drain
        logic [2:0] led; // 1 = LED function
        logic [2:0] outv;
        logic aw_got;
        logic [7:0] aw_addr;
        logic w_got;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        gledi_blink_t phase;
        logic [CW-1:0] cnt;
        logic act_seen;
        logic [2:0] pin_out;
        logic [2:0] pin_oe;
    } gledi_state_t;

    gledi_state_t st_q;
    gledi_state_t st_d;

    logic [2:0] pin_in_s;
    logic [4:0] stat_s;
    logic [2:0] led_val;
    logic [31:0] cfg_word;
    logic [31:0] wr_merge;

    // ****************************************
    // Input synchronisers
    // ****************************************
    // Pins come from outside the clock domain
    gledi_sync2 #(
        .WIDTH(3)
    ) u_pin_sync (
        .clock(clock),
        .srst(srst),
        .async_in(pin_in),
        .sync_out(pin_in_s)
    );

    // Status order: link, speed, duplex, tx, rx
    gledi_sync2 #(
        .WIDTH(5)
    ) u_stat_sync (
        .clock(clock),
        .srst(srst),
        .async_in({link_up, speed_10, full_duplex, tx_activity, rx_activity}),
        .sync_out(stat_s)
    );

    // ****************************************
    // Read-back word and indicator levels
    // ****************************************
    // Combinational helpers
    always_comb begin
        // Config word as software reads it back
        cfg_word = 32'h0000_0000;
        cfg_word[GLEDI_CFG_DIR_LSB +: GLEDI_NPINS] = st_q.dir;
        cfg_word[GLEDI_CFG_OD_LSB +: GLEDI_NPINS] = st_q.od;
        cfg_word[GLEDI_CFG_LED_LSB +: GLEDI_NPINS] = st_q.led;
        // Byte-lane merge of the held write data
        wr_merge = cfg_word;
        for (int b = 0; b < 4; b++) begin
            if (st_q.w_strb[b]) begin
                wr_merge[b*8 +: 8] = st_q.w_data[b*8 +: 8];
            end
        end
        // Indicator levels, active low
        // Speed level follows speed_10, high only at 10 Mb/s
        led_val[0] = stat_s[3];
        if (!stat_s[4]) begin
            led_val[1] = 1'b1;
        end else begin
            led_val[1] = (st_q.phase == GLEDI_OFF);
        end
        led_val[2] = ~(stat_s[4] & stat_s[2]);
    end

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        st_d = st_q;
        // Write channel capture
        // Each half is held until the other arrives
        if (s_axi_awvalid && !st_q.aw_got && !st_q.bvalid) begin
            st_d.aw_got = 1'b1;
            st_d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st_q.w_got && !st_q.bvalid) begin
            st_d.w_got = 1'b1;
            st_d.w_data = s_axi_wdata;
            st_d.w_strb = s_axi_wstrb;
        end
        // Perform write once both halves are held
        if (st_q.aw_got && st_q.w_got) begin
            st_d.aw_got = 1'b0;
            st_d.w_got = 1'b0;
            st_d.bvalid = 1'b1;
            st_d.bresp = GLEDI_RESP_OKAY;
            case (st_q.aw_addr)
                GLEDI_CFG_ADDR: begin
                    st_d.dir = wr_merge[GLEDI_CFG_DIR_LSB +: GLEDI_NPINS];
                    st_d.od = wr_merge[GLEDI_CFG_OD_LSB +: GLEDI_NPINS];
                    st_d.led = wr_merge[GLEDI_CFG_LED_LSB +: GLEDI_NPINS];
                end
                GLEDI_OUT_ADDR: begin
                    if (st_q.w_strb[0]) begin
                        st_d.outv = st_q.w_data[2:0];
                    end
                end
                GLEDI_STAT_ADDR: begin
                    // Status is read-only, writes are ignored
                end
                default: begin
                    st_d.bresp = GLEDI_RESP_SLVERR;
                end
            endcase
        end
        // Response stands until bready
        if (st_q.bvalid && s_axi_bready) begin
            st_d.bvalid = 1'b0;
        end
        // Read channel
        // A new read waits until the last answer is taken
        if (s_axi_arvalid && !st_q.rvalid) begin
            st_d.rvalid = 1'b1;
            st_d.rresp = GLEDI_RESP_OKAY;
            case (s_axi_araddr)
                GLEDI_CFG_ADDR: begin
                    st_d.rdata = cfg_word;
                end
                GLEDI_OUT_ADDR: begin
                    st_d.rdata = {29'h0000_0000, st_q.outv};
                end
                GLEDI_STAT_ADDR: begin
                    st_d.rdata = {21'h00_0000, stat_s, led_val, pin_in_s};
                end
                default: begin
                    // Unmapped reads return zero
                    st_d.rdata = 32'h0000_0000;
                    st_d.rresp = GLEDI_RESP_SLVERR;
                end
            endcase
        end else if (st_q.rvalid && s_axi_rready) begin
            st_d.rvalid = 1'b0;
        end
        // Link/activity blink sequence
        // Remember activity seen during the on phase
        if (stat_s[1] || stat_s[0]) begin
            st_d.act_seen = 1'b1;
        end
        case (st_q.phase)
            GLEDI_IDLE: begin
                // Idle clears the flag; live activity still starts a pulse
                st_d.act_seen = 1'b0;
                if (stat_s[4] && (stat_s[1] || stat_s[0] || st_q.act_seen)) begin
                    st_d.phase = GLEDI_OFF;
                    st_d.cnt = CW'(BLINK_CYCLES - 1);
                end
            end
            GLEDI_OFF: begin
                if (st_q.cnt == '0) begin
                    st_d.phase = GLEDI_ON;
                    st_d.cnt = CW'(BLINK_CYCLES - 1);
                    // Activity in this very cycle still counts
                    st_d.act_seen = stat_s[1] | stat_s[0];
                end else begin
                    st_d.cnt = st_q.cnt - 1'b1;
                end
            end
            GLEDI_ON: begin
                // Pending activity starts the next pulse at once
                if (st_q.cnt != '0) begin
                    st_d.cnt = st_q.cnt - 1'b1;
                end else if (stat_s[1] || stat_s[0] || st_q.act_seen) begin
                    st_d.phase = GLEDI_OFF;
                    st_d.cnt = CW'(BLINK_CYCLES - 1);
                    st_d.act_seen = 1'b0;
                end else begin
                    st_d.phase = GLEDI_IDLE;
                end
            end
            default: begin
                st_d.phase = GLEDI_IDLE;
            end
        endcase
        // Lost link aborts any blink
        if (!stat_s[4]) begin
            st_d.phase = GLEDI_IDLE;
            st_d.cnt = '0;
            st_d.act_seen = 1'b0;
        end
        // Pin drivers
        // LED pins only sink; a dark LED releases the pin
        for (int i = 0; i < GLEDI_NPINS; i++) begin
            if (st_q.led[i]) begin
                st_d.pin_out[i] = 1'b0;
                st_d.pin_oe[i] = ~led_val[i];
            end else if (!st_q.dir[i]) begin
                st_d.pin_out[i] = 1'b0;
                st_d.pin_oe[i] = 1'b0;
            end else if (st_q.od[i]) begin
                st_d.pin_out[i] = 1'b0;
                st_d.pin_oe[i] = ~st_q.outv[i];
            end else begin
                st_d.pin_out[i] = st_q.outv[i];
                st_d.pin_oe[i] = 1'b1;
            end
        end
    end

    // ****************************************
    // State register
    // ****************************************
    // Registered state
    always_ff @(posedge clock) begin
        if (srst) begin
            // Clear all, then config to its reset layout
            st_q <= '0;
            st_q.dir <= GLEDI_CFG_RESET[GLEDI_CFG_DIR_LSB +: GLEDI_NPINS];
            st_q.od <= GLEDI_CFG_RESET[GLEDI_CFG_OD_LSB +: GLEDI_NPINS];
            st_q.led <= GLEDI_CFG_RESET[GLEDI_CFG_LED_LSB +: GLEDI_NPINS];
            st_q.outv <= GLEDI_OUT_RESET;
            st_q.phase <= GLEDI_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    // Write channel, both ready low while a response waits
    assign s_axi_awready = ~st_q.aw_got & ~st_q.bvalid;
    assign s_axi_wready = ~st_q.w_got & ~st_q.bvalid;
    assign s_axi_bvalid = st_q.bvalid;
    assign s_axi_bresp = st_q.bresp;

    // Read channel, one read at a time
    assign s_axi_arready = ~st_q.rvalid;
    assign s_axi_rvalid = st_q.rvalid;
    assign s_axi_rdata = st_q.rdata;
    assign s_axi_rresp = st_q.rresp;

    // Pin drive straight from flip-flops
    assign pin_out = st_q.pin_out;
    assign pin_oe = st_q.pin_oe;
endmodule

// *** include/gledi_pkg.sv ***
// Package of constants and types for the general pin and LED indicator block
package gledi_pkg;
    // ****************************************
    // Register byte addresses
    // ****************************************
    localparam logic [7:0] GLEDI_CFG_ADDR = 8'h00;
    localparam logic [7:0] GLEDI_OUT_ADDR = 8'h04;
    localparam logic [7:0] GLEDI_STAT_ADDR = 8'h08;

    // ****************************************
    // Configuration field layout
    // ****************************************
    localparam int GLEDI_CFG_DIR_LSB = 0;
    localparam int GLEDI_CFG_OD_LSB = 8;
    localparam int GLEDI_CFG_LED_LSB = 16;
    localparam int GLEDI_NPINS = 3;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [31:0] GLEDI_CFG_RESET = 32'h0000_0000;
    localparam logic [2:0] GLEDI_OUT_RESET = 3'h0;

    // ****************************************
    // Timing
    // ****************************************
    localparam int GLEDI_CLK_MHZ = 125;
    localparam int GLEDI_BLINK_MS = 80;
    localparam int GLEDI_BLINK_CYCLES = GLEDI_BLINK_MS * 1000 * GLEDI_CLK_MHZ;

    // ****************************************
    // AXI responses
    // ****************************************
    localparam logic [1:0] GLEDI_RESP_OKAY = 2'h0;
    localparam logic [1:0] GLEDI_RESP_SLVERR = 2'h2;

    // Link/activity blink phases
    typedef enum logic [1:0] {
        GLEDI_IDLE,
        GLEDI_OFF,
        GLEDI_ON
    } gledi_blink_t;
endpackage

// *** src/gledi_sync2.sv ***
// Two flip-flop synchroniser for a vector of asynchronous inputs
`timescale 1ns/1ns
module gledi_sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic clock, // Core clock
    input wire logic srst, // Synchronous reset
    input wire logic [WIDTH-1:0] async_in, // Unsynchronised inputs
    output logic [WIDTH-1:0] sync_out // Synchronised inputs
);
    typedef struct packed {
        logic [WIDTH-1:0] first;
        logic [WIDTH-1:0] second;
    } gledi_sync_t;

    gledi_sync_t st_q;
    gledi_sync_t st_d;

    // Shift through two stages
    always_comb begin
        st_d.first = async_in;
        st_d.second = st_q.first;
    end

    // State register
    always_ff @(posedge clock) begin
        if (srst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign sync_out = st_q.second;
endmodule

// *** verification/gledi_asserts.sv ***
// Checker of pin drive and indicator timing
`timescale 1ns/1ns
module gledi_asserts
    import gledi_pkg::*;
#(
    parameter int BLINK_CYCLES = GLEDI_BLINK_CYCLES
) (
    input wire logic clock, // Clock
    input wire logic srst, // Reset
    input wire logic [7:0] s_axi_awaddr, // Addr
    input wire logic s_axi_awvalid, // Valid
    input wire logic s_axi_awready, // Ready
    input wire logic [31:0] s_axi_wdata, // Data
    input wire logic s_axi_wvalid, // Valid
    input wire logic s_axi_wready, // Ready
    input wire logic link_up, // Link
    input wire logic speed_10, // Speed
    input wire logic full_duplex, // Duplex
    input wire logic [2:0] pin_out, // Drive
    input wire logic [2:0] pin_oe // Enable
);
    logic [31:0] cfg_q;
    logic [2:0] led;
    logic ok;
    int st_q, off_q, on_q, lk_q;
    default clocking @(posedge clock); endclocking
    default disable iff (srst);
    assign led = cfg_q[18:16];
    assign ok = st_q == 8;
    // Snooped config, settle time and run lengths
    always_ff @(posedge clock) begin
        off_q <= pin_oe[1] ? 0 : off_q + 1;
        on_q <= pin_oe[1] ? on_q + 1 : 0;
        lk_q <= link_up ? lk_q + 1 : 0;
        if (srst) begin
            cfg_q <= GLEDI_CFG_RESET;
            st_q <= 0;
        end else if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
                     && s_axi_awaddr == GLEDI_CFG_ADDR) begin
            cfg_q <= s_axi_wdata;
            st_q <= 0;
        end else if (!ok) begin
            st_q <= st_q + 1;
        end
    end
    in_undriven_a: assert property (ok |-> (pin_oe & ~cfg_q[2:0] & ~led) == 3'h0)
        else $error("input pin driven");
    led_od_a: assert property (ok |-> (pin_out & led) == 3'h0)
        else $error("led pin driven high");
    speed_hi_a: assert property ((ok && led[0] && speed_10)[*6] |-> !pin_oe[0])
        else $error("speed pin not released");
    speed_lo_a: assert property ((ok && led[0] && !speed_10)[*6] |-> pin_oe[0])
        else $error("speed pin not lit");
    off_len_a: assert property ($rose(pin_oe[1]) && ok && led[1] && lk_q > off_q + 8
        |-> off_q == BLINK_CYCLES)
        else $error("off phase length");
    on_len_a: assert property ($fell(pin_oe[1]) && ok && led[1] && lk_q > on_q + 8
        |-> on_q >= BLINK_CYCLES)
        else $error("on phase too short");
    duplex_lit_a: assert property ((ok && led[2] && link_up && full_duplex)[*6]
        |-> pin_oe[2])
        else $error("duplex pin not lit");
    nolink_off_a: assert property ((ok && led[1] && !link_up)[*6] |-> !pin_oe[1])
        else $error("link pin lit without link");
    cover property ($rose(pin_oe[1]) && led[1]);
    cover property ($fell(pin_oe[1]) && led[1]);
    cover property (ok && led == 3'h7);
endmodule
bind gledi_top gledi_asserts #(.BLINK_CYCLES(BLINK_CYCLES)) u_chk (.*);

// *** verification/gledi_pins.sv ***
// Board model of the three pins with pull-ups
`timescale 1ns/1ns
module gledi_pins (
    input wire logic [2:0] pin_out, // Device level
    input wire logic [2:0] pin_oe, // Device enable
    input wire logic [2:0] ext_en, // Board drives
    input wire logic [2:0] ext_val, // Board level
    output logic [2:0] pin_in // Wire level
);
    // Device drive, else board drive, else pull-up
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val) | (~pin_oe & ~ext_en);
endmodule

// *** verification/gledi_bench.sv ***
// Self-checking bench of the pin and indicator block
`timescale 1ns/1ns
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin num_errors++; \
    $display("unexpected at %0t: got %h want %h", $time, (a), (e)); end end
module gledi_bench
    import gledi_pkg::*;
;
    logic clock = 1'h0, srst = 1'h1;
    logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0, rnd = 8'h06;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, s_axi_awready, s_axi_wready;
    logic link_up = 1'h0, speed_10 = 1'h0, full_duplex = 1'h0;
    logic tx_activity = 1'h0, rx_activity = 1'h0, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, w;
    logic [2:0] pin_in, pin_out, pin_oe, x, ext_en = '0, ext_val = '0;
    logic [1:0] wq[$];
    logic [33:0] rq[$];
    logic [33:0] e;
    int num_errors = 0, compares = 0, n, i;
    gledi_top #(.BLINK_CYCLES(20)) u_dut (.*);
    gledi_pins u_pins (.*);
    // Clock of 8 ns period
    initial begin
        forever #4 clock = ~clock;
    end
    function automatic logic [7:0] nx(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        logic ta, tw, tb;
        wq.push_back(r);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(negedge clock);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            tb = s_axi_bvalid;
            @(posedge clock);
            if (ta) s_axi_awvalid <= 1'h0;
            if (tw) s_axi_wvalid <= 1'h0;
        end while (!tb);
        s_axi_bready <= 1'h0;
        @(posedge clock);
    endtask
    task automatic rd(input logic [7:0] a, input logic [33:0] xp);
        logic ta, tr;
        rq.push_back(xp);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(negedge clock);
            ta = s_axi_arvalid && s_axi_arready;
            tr = s_axi_rvalid;
            @(posedge clock);
            if (ta) s_axi_arvalid <= 1'h0;
        end while (!tr);
        s_axi_rready <= 1'h0;
        @(posedge clock);
    endtask
    // Length of the current link pin run
    task automatic run_len(input logic v);
        n = 0;
        while (pin_oe[1] === v && n < 60) begin
            n++;
            @(negedge clock);
        end
    endtask
    task automatic complete_run();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Compare each bus answer with the oldest note
    always @(negedge clock) begin
        if (s_axi_bvalid && s_axi_bready) begin
            w = wq.pop_front();
            `CHK(s_axi_bresp, w)
        end
        if (s_axi_rvalid && s_axi_rready) begin
            e = rq.pop_front();
            `CHK({s_axi_rresp, s_axi_rdata}, e)
        end
    end
    // Watchdog for a hung run
    initial begin
        #100000;
        num_errors++;
        complete_run();
    end
    // ****
    // Main sequence
    // ****
    initial begin
        repeat (8) @(posedge clock);
        srst <= 1'h0;
        @(posedge clock);
        `CHK(pin_oe, 3'h0)
        rd(GLEDI_CFG_ADDR, {GLEDI_RESP_OKAY, GLEDI_CFG_RESET});
        wr(GLEDI_CFG_ADDR, 32'h0000_0207, GLEDI_RESP_OKAY);
        wr(GLEDI_OUT_ADDR, 32'h0000_0005, GLEDI_RESP_OKAY);
        repeat (4) @(posedge clock);
        `CHK({pin_oe, pin_out}, 6'h3d)
        wr(GLEDI_OUT_ADDR, 32'h0000_0002, GLEDI_RESP_OKAY);
        repeat (4) @(posedge clock);
        `CHK({pin_oe, pin_out}, 6'h28)
        rd(GLEDI_STAT_ADDR, {GLEDI_RESP_OKAY, 32'h0000_0032});
        rd(8'h0c, {GLEDI_RESP_SLVERR, 32'h0000_0000});
        wr(8'h10, 32'h0000_0007, GLEDI_RESP_SLVERR);
        rd(GLEDI_CFG_ADDR, {GLEDI_RESP_OKAY, 32'h0000_0207});
        wr(GLEDI_CFG_ADDR, 32'h0000_0000, GLEDI_RESP_OKAY);
        ext_en <= 3'h7;
        repeat (4) begin
            rnd = nx(rnd);
            ext_val <= rnd[2:0];
            repeat (4) @(posedge clock);
            `CHK(pin_oe, 3'h0)
            rd(GLEDI_STAT_ADDR, {GLEDI_RESP_OKAY, 26'h0, 3'h6, rnd[2:0]});
        end
        ext_en <= 3'h0;
        wr(GLEDI_CFG_ADDR, 32'h0007_0007, GLEDI_RESP_OKAY);
        wr(GLEDI_OUT_ADDR, 32'h0000_0007, GLEDI_RESP_OKAY);
        for (i = 0; i < 8; i++) begin
            if (i[2:1] == 2'h1) continue;
            {link_up, speed_10, full_duplex} <= i[2:0];
            repeat (6) @(posedge clock);
            x = {i[2] & i[0], i[2], ~i[1]};
            `CHK(pin_oe, x)
            `CHK(pin_out, 3'h0)
            rd(GLEDI_STAT_ADDR, {GLEDI_RESP_OKAY, 21'h0, i[2:0], 2'h0, ~x, ~x});
        end
        {link_up, speed_10, full_duplex} <= 3'h5;
        rx_activity <= 1'h1;
        @(negedge clock);
        run_len(1'h1);
        run_len(1'h0);
        `CHK(n, 20)
        @(posedge clock);
        rx_activity <= 1'h0;
        tx_activity <= 1'h1;
        run_len(1'h1);
        `CHK(n, 20)
        run_len(1'h0);
        `CHK(n, 20)
        run_len(1'h1);
        repeat (5) @(posedge clock);
        link_up <= 1'h0;
        repeat (6) @(negedge clock);
        run_len(1'h0);
        `CHK(n, 60)
        @(posedge clock);
        tx_activity <= 1'h0;
        link_up <= 1'h1;
        repeat (6) @(negedge clock);
        run_len(1'h1);
        `CHK(n, 60)
        complete_run();
    end
endmodule
